// ==== rtl/mmhi_pkg.sv ====
package mmhi_pkg;

   // protocol straps packed as {bit2, bit1, bit0}
   localparam logic [2:0] STRAP_I2C = 3'h2;
   localparam logic [2:0] STRAP_SPI3 = 3'h1;
   localparam logic [2:0] STRAP_SPI4 = 3'h0;
   localparam logic [2:0] STRAP_P68 = 3'h4;
   localparam logic [2:0] STRAP_P80 = 3'h6;

   // cycles after rst before the straps are taken
   localparam logic [1:0] STRAP_SETTLE = 2'h3;

   // values after hardware reset
   localparam logic [7:0] CONTRAST_RST = 8'h7f;
   localparam logic [6:0] COLUMN_RST = 7'h00;
   localparam logic DISP_ON_RST = 1'b0;

   // command bytes seen on the drain side
   localparam logic [7:0] CMD_CONTRAST = 8'h81;
   localparam logic [7:0] CMD_DISP_OFF = 8'hae;
   localparam logic [7:0] CMD_DISP_ON = 8'haf;

   // pin roles on the host bus
   localparam int PIN_SCLK = 0;
   localparam int PIN_SERIAL_IN = 1;
   localparam int PIN_SDA_OUT = 2;
   localparam int CTRL_DC_BIT = 6;
   localparam logic [7:0] BUS_RELEASE = 8'hff;

   // serial bit counts at the last bit of a frame
   localparam logic [3:0] SPI4_LAST = 4'h7;
   localparam logic [3:0] SPI3_LAST = 4'h8;
   localparam logic [3:0] I2C_BYTE_BITS = 4'h8;

   // buffer shape
   localparam int FIFO_DEPTH = 16;
   localparam int WORD_WIDTH = 9;

   typedef enum logic [2:0] {
      PROTO_NONE, PROTO_I2C, PROTO_SPI3, PROTO_SPI4, PROTO_P68, PROTO_P80
   } mmhi_proto_type;

   typedef enum logic [2:0] {
      I2C_IDLE, I2C_ADDR, I2C_CTRL, I2C_DATA, I2C_SKIP
   } mmhi_i2c_type;

   typedef struct packed {
      logic is_data;
      logic [7:0] byte_val;
   } mmhi_word_type;

   typedef struct packed {
      logic cs_n;
      logic dc;
      logic rw;
      logic erd;
      logic res_n;
      logic [2:0] strap;
      logic [7:0] bus;
   } mmhi_pins_type;

   localparam mmhi_pins_type PINS_IDLE = '{cs_n: 1'b1, dc: 1'b0, rw: 1'b1, erd: 1'b1,
                                           res_n: 1'b1, strap: 3'h0, bus: 8'h00};

   function automatic mmhi_proto_type mmhi_decode_proto(input logic [2:0] strap);
      mmhi_proto_type m;
      m = PROTO_NONE;
      if (strap == STRAP_I2C) begin
         m = PROTO_I2C;
      end else if (strap == STRAP_SPI3) begin
         m = PROTO_SPI3;
      end else if (strap == STRAP_SPI4) begin
         m = PROTO_SPI4;
      end else if (strap == STRAP_P68) begin
         m = PROTO_P68;
      end else if (strap == STRAP_P80) begin
         m = PROTO_P80;
      end
      return m;
   endfunction

endpackage

// ==== rtl/mmhi_top.sv ====
// Summary of operation
// - three straps pick I2C, SPI or parallel
// - transfers only while select is low
// - low hardware reset initialises the controller
// - parallel: data-select high data, low command
// - 4-wire SPI: data-select high data, low command; 3-wire SPI takes it from the leading frame bit
// - I2C: data-select is slave address bit
// - 68xx: direction high reads, low writes
// - 68xx: enable high with select starts transfer
// - 80xx: write strobe low with select writes
// - 80xx: read strobe low drives the bus
// - parallel: eight-bit two-way data bus
// - SPI: data on pin 1, clock pin 0
// - I2C: pins 2/1 SDA, pin 0 SCL
// - hardware reset clears serial shift register
// - reset: contrast 7Fh, column 0, display off
`timescale 1ns/10ps

module mmhi_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
      logic in_ready;
      logic out_valid;
   } mmhi_fifo_state_type;

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
         $error("fifo depth must be a power of two of at least two");
      end
      if (WIDTH < 1) begin : g_bad_width
         $error("fifo width must be at least one");
      end
   endgenerate

   mmhi_fifo_state_type r;
   mmhi_fifo_state_type n;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign push = in_valid & r.in_ready;
   assign pop = r.out_valid & out_ready;

   always_comb begin
      n = r;
      if (push) begin
         n.wptr = r.wptr + 1'b1;
      end
      if (pop) begin
         n.rptr = r.rptr + 1'b1;
      end
      if (push && !pop) begin
         n.count = r.count + 1'b1;
      end else if (pop && !push) begin
         n.count = r.count - 1'b1;
      end
      // flags registered from the next count, so they never lie
      n.in_ready = n.count != FULL;
      n.out_valid = n.count != '0;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
         r.in_ready <= 1'b1;
      end else begin
         r <= n;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[r.wptr] <= in_data;
      end
   end

   assign in_ready = r.in_ready;
   assign out_valid = r.out_valid;
   assign out_data = mem[r.rptr];
endmodule

module mmhi_top #(
   parameter logic [5:0] I2C_ADDR_HI = 6'h2a,
   parameter int FIFO_DEPTH_P = mmhi_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host pins, sampled raw
   input wire logic cs_n,
   input wire logic dc_sel,
   input wire logic rw_wr_n,
   input wire logic en_rd_n,
   input wire logic hw_reset_n,
   input wire logic proto_strap_bit0,
   input wire logic proto_strap_bit1,
   input wire logic proto_strap_bit2,
   // two-way host bus
   input wire logic [7:0] host_bus_in,
   output logic [7:0] host_bus_out,
   output logic [7:0] host_bus_oe_n,
   // received command and data stream
   output logic word_valid,
   input wire logic word_ready,
   output mmhi_pkg::mmhi_word_type word,
   // status
   output mmhi_pkg::mmhi_proto_type proto_mode,
   output logic [7:0] contrast,
   output logic [6:0] column_addr,
   output logic display_on,
   output logic overrun,
   output logic hw_reset_n_sync
);
   import mmhi_pkg::*;

   typedef struct packed {
      mmhi_pins_type s1;
      mmhi_pins_type s2;
      mmhi_pins_type s3;
      mmhi_pins_type f;
      mmhi_pins_type p;
      logic [1:0] settle;
      logic mode_set;
      mmhi_proto_type mode;
      logic [8:0] shift;
      logic [3:0] bits;
      mmhi_i2c_type i2c;
      logic i2c_dc;
      logic i2c_data_drive;
      logic hold_v;
      mmhi_word_type hold;
      logic overrun;
      logic [7:0] contrast;
      logic [6:0] column;
      logic disp_on;
      logic arg_pend;
      logic [7:0] bus_out;
      logic [7:0] bus_oe_n;
   } mmhi_state_type;

   mmhi_state_type r;
   mmhi_state_type n;
   mmhi_pins_type pins;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [WORD_WIDTH-1:0] fifo_out_data;
   mmhi_word_type pop_word;

   assign pins = '{cs_n: cs_n, dc: dc_sel, rw: rw_wr_n, erd: en_rd_n, res_n: hw_reset_n,
                   strap: {proto_strap_bit2, proto_strap_bit1, proto_strap_bit0},
                   bus: host_bus_in};
   assign pop_word = mmhi_word_type'(fifo_out_data);

   mmhi_fifo #(
      .WIDTH(WORD_WIDTH),
      .DEPTH(FIFO_DEPTH_P)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(r.hold_v),
      .in_ready(fifo_in_ready),
      .in_data(r.hold),
      .out_valid(fifo_out_valid),
      .out_ready(word_ready),
      .out_data(fifo_out_data)
   );

   always_comb begin
      logic word_new;
      mmhi_word_type word_val;
      logic act;
      logic pact;
      logic scl;
      logic pscl;
      logic sda;
      logic psda;
      logic scl_rise;
      logic scl_fall;
      logic [7:0] rx;
      logic [7:0] status;
      n = r;
      word_new = 1'b0;
      word_val = '0;
      act = 1'b0;
      pact = 1'b0;
      rx = r.shift[7:0];
      // three-stage pin capture, a bit moves once stages two and three agree
      n.s1 = pins;
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.f = mmhi_pins_type'((r.f & (r.s2 ^ r.s3)) | (r.s2 & ~(r.s2 ^ r.s3)));
      n.p = r.f;
      scl = r.f.bus[PIN_SCLK];
      pscl = r.p.bus[PIN_SCLK];
      sda = r.f.bus[PIN_SERIAL_IN];
      psda = r.p.bus[PIN_SERIAL_IN];
      scl_rise = scl & ~pscl;
      scl_fall = ~scl & pscl;
      status = {r.hold_v, ~r.disp_on, 6'h00};
      // straps taken once the capture pipeline has filled
      if (!r.mode_set) begin
         if (r.settle == STRAP_SETTLE) begin
            // straps enter the filtered stage on this very edge
            n.mode = mmhi_decode_proto(n.f.strap);
            n.mode_set = 1'b1;
         end else begin
            n.settle = r.settle + 2'h1;
         end
      end
      if (r.hold_v && fifo_in_ready) begin
         n.hold_v = 1'b0;
      end
      n.bus_oe_n = BUS_RELEASE;
      n.bus_out = 8'h00;
      if (!r.f.res_n) begin
         n.shift = '0;
         n.bits = '0;
         n.i2c = I2C_IDLE;
         n.i2c_dc = 1'b0;
         n.i2c_data_drive = 1'b0;
         n.arg_pend = 1'b0;
         n.contrast = CONTRAST_RST;
         n.column = COLUMN_RST;
         n.disp_on = DISP_ON_RST;
      end else begin
         case (r.mode)
            PROTO_P68: begin
               act = ~r.f.cs_n & r.f.erd;
               pact = ~r.p.cs_n & r.p.erd;
               if (pact && !act && !r.p.rw) begin
                  word_new = 1'b1;
                  word_val = '{is_data: r.p.dc, byte_val: r.p.bus};
               end
               if (act && r.f.rw) begin
                  n.bus_oe_n = 8'h00;
                  n.bus_out = status;
               end
            end
            PROTO_P80: begin
               act = ~r.f.cs_n & ~r.f.rw;
               pact = ~r.p.cs_n & ~r.p.rw;
               if (pact && !act) begin
                  word_new = 1'b1;
                  word_val = '{is_data: r.p.dc, byte_val: r.p.bus};
               end
               if (!r.f.cs_n && !r.f.erd) begin
                  n.bus_oe_n = 8'h00;
                  n.bus_out = status;
               end
            end
            PROTO_SPI3, PROTO_SPI4: begin
               if (r.f.cs_n) begin
                  n.bits = '0;
                  n.shift = '0;
               end else if (scl_rise) begin
                  n.shift = {r.shift[7:0], sda};
                  n.bits = r.bits + 4'h1;
                  if (r.mode == PROTO_SPI4 && r.bits == SPI4_LAST) begin
                     word_new = 1'b1;
                     word_val = '{is_data: r.f.dc, byte_val: {r.shift[6:0], sda}};
                     n.bits = '0;
                  end else if (r.mode == PROTO_SPI3 && r.bits == SPI3_LAST) begin
                     // leading bit of the nine-bit frame carries data-select
                     word_new = 1'b1;
                     word_val = '{is_data: r.shift[7], byte_val: {r.shift[6:0], sda}};
                     n.bits = '0;
                  end
               end
            end
            PROTO_I2C: begin
               if (r.f.cs_n) begin
                  n.i2c = I2C_IDLE;
                  n.i2c_data_drive = 1'b0;
               end else if (scl && pscl && psda && !sda) begin
                  n.i2c = I2C_ADDR;
                  n.bits = '0;
                  n.i2c_data_drive = 1'b0;
               end else if (scl && pscl && !psda && sda) begin
                  n.i2c = I2C_IDLE;
                  n.i2c_data_drive = 1'b0;
               end else if (r.i2c != I2C_IDLE && r.i2c != I2C_SKIP) begin
                  if (scl_rise && !r.i2c_data_drive) begin
                     n.shift = {r.shift[7:0], sda};
                     n.bits = r.bits + 4'h1;
                  end else if (scl_fall && r.i2c_data_drive) begin
                     n.i2c_data_drive = 1'b0;
                  end else if (scl_fall && r.bits == I2C_BYTE_BITS) begin
                     n.bits = '0;
                     n.i2c_data_drive = 1'b1;
                     case (r.i2c)
                        I2C_ADDR: begin
                           // write-only slave, low address bit from data-select
                           if (rx == {I2C_ADDR_HI, r.f.dc, 1'b0}) begin
                              n.i2c = I2C_CTRL;
                           end else begin
                              n.i2c = I2C_SKIP;
                              n.i2c_data_drive = 1'b0;
                           end
                        end
                        I2C_CTRL: begin
                           n.i2c_dc = rx[CTRL_DC_BIT];
                           n.i2c = I2C_DATA;
                        end
                        I2C_DATA: begin
                           word_new = 1'b1;
                           word_val = '{is_data: r.i2c_dc, byte_val: rx};
                        end
                        default: begin
                           n.i2c_data_drive = 1'b0;
                        end
                     endcase
                  end
               end
               // acknowledge pulls the output half of SDA low
               n.bus_oe_n[PIN_SDA_OUT] = ~n.i2c_data_drive;
            end
            default: begin
            end
         endcase
         if (word_new) begin
            if (!n.hold_v) begin
               n.hold_v = 1'b1;
               n.hold = word_val;
            end else begin
               n.overrun = 1'b1;
            end
         end
         // light decode of the drained stream
         if (fifo_out_valid && word_ready) begin
            if (pop_word.is_data) begin
               n.column = r.column + 7'h01;
            end else if (r.arg_pend) begin
               n.contrast = pop_word.byte_val;
               n.arg_pend = 1'b0;
            end else if (pop_word.byte_val == CMD_CONTRAST) begin
               n.arg_pend = 1'b1;
            end else if (pop_word.byte_val == CMD_DISP_OFF) begin
               n.disp_on = 1'b0;
            end else if (pop_word.byte_val == CMD_DISP_ON) begin
               n.disp_on = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
         r.s1 <= PINS_IDLE;
         r.s2 <= PINS_IDLE;
         r.s3 <= PINS_IDLE;
         r.f <= PINS_IDLE;
         r.p <= PINS_IDLE;
         r.mode <= PROTO_NONE;
         r.i2c <= I2C_IDLE;
         r.contrast <= CONTRAST_RST;
         r.column <= COLUMN_RST;
         r.disp_on <= DISP_ON_RST;
         r.bus_oe_n <= BUS_RELEASE;
      end else begin
         r <= n;
      end
   end

   assign host_bus_out = r.bus_out;
   assign host_bus_oe_n = r.bus_oe_n;
   assign word_valid = fifo_out_valid;
   assign word = pop_word;
   assign proto_mode = r.mode;
   assign contrast = r.contrast;
   assign column_addr = r.column;
   assign display_on = r.disp_on;
   assign overrun = r.overrun;
   assign hw_reset_n_sync = r.f.res_n;
endmodule

// ==== sim/mmhi_monitor.sv ====
`timescale 1ns/10ps
module mmhi_mon (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host pins
   input wire logic cs_n,
   input wire logic rw_wr_n,
   input wire logic en_rd_n,
   input wire logic hw_reset_n,
   input wire logic [7:0] host_bus_out,
   input wire logic [7:0] host_bus_oe_n,
   // stream and status
   input wire logic word_valid,
   input wire logic word_ready,
   input wire mmhi_pkg::mmhi_word_type word,
   input wire mmhi_pkg::mmhi_proto_type proto_mode,
   input wire logic [7:0] contrast,
   input wire logic [6:0] column_addr,
   input wire logic display_on,
   input wire logic overrun,
   input wire logic hw_reset_n_sync
);
   import mmhi_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   rst_exit_a: assert property ($fell(rst) |-> host_bus_oe_n == 8'hff &&
      proto_mode == PROTO_NONE && !word_valid) else $error("bad state after reset");
   hw_init_a: assert property ((!hw_reset_n_sync)[*2] |-> contrast == CONTRAST_RST &&
      column_addr == COLUMN_RST && display_on == DISP_ON_RST) else $error("bad hw reset state");
   mode_hold_a: assert property (proto_mode != PROTO_NONE |=> $stable(proto_mode))
      else $error("mode changed");
   deselect_idle_a: assert property (cs_n[*8] |-> host_bus_oe_n == 8'hff)
      else $error("bus driven while deselected");
   serial_pins_a: assert property (proto_mode inside {PROTO_SPI3, PROTO_SPI4, PROTO_I2C}
      |-> (host_bus_oe_n | 8'h04) == 8'hff) else $error("serial pin driven");
   w80_release_a: assert property ((proto_mode == PROTO_P80 && en_rd_n)[*8]
      |-> host_bus_oe_n == 8'hff) else $error("bus driven without read");
   w68_release_a: assert property ((proto_mode == PROTO_P68 && !rw_wr_n)[*8]
      |-> host_bus_oe_n == 8'hff) else $error("bus driven on write");
   rd80_drive_a: assert property ((proto_mode == PROTO_P80 && !en_rd_n && !cs_n
      && hw_reset_n)[*8] |-> host_bus_oe_n == 8'h00 && host_bus_out[6] == !display_on)
      else $error("read not driven");
   rd68_drive_a: assert property ((proto_mode == PROTO_P68 && en_rd_n && rw_wr_n && !cs_n
      && hw_reset_n)[*8] |-> host_bus_oe_n == 8'h00) else $error("read not driven");
   word_hold_a: assert property (word_valid && !word_ready |=> word_valid && $stable(word))
      else $error("word dropped while stalled");

   cover property (word_valid && word_ready && word.is_data);
   cover property (overrun);
   cover property (proto_mode == PROTO_P80 && host_bus_oe_n == 8'h00);
   cover property (proto_mode == PROTO_I2C && host_bus_oe_n[2] == 1'b0);
endmodule

bind mmhi_top mmhi_mon u_mon (.clk, .rst, .cs_n, .rw_wr_n, .en_rd_n, .hw_reset_n,
   .host_bus_out, .host_bus_oe_n, .word_valid, .word_ready, .word, .proto_mode,
   .contrast, .column_addr, .display_on, .overrun, .hw_reset_n_sync);

// ==== sim/mmhi_host.sv ====
`timescale 1ns/10ps
module mmhi_host (
   // clock
   input wire logic clk,
   // host pins
   output logic cs_n,
   output logic dc_sel,
   output logic rw_wr_n,
   output logic en_rd_n,
   output logic [7:0] drv,
   output logic drv_en,
   input wire logic [7:0] bus_in
);
   initial begin
      cs_n = 1'b1;
      dc_sel = 1'b0;
      rw_wr_n = 1'b1;
      en_rd_n = 1'b1;
      drv = 8'h00;
      drv_en = 1'b1;
   end
   task automatic st(input int n);
      repeat (n) @(posedge clk);
   endtask
   // serial clock idles low outside frames
   task automatic spi(input logic three, input logic sel, input logic d, input logic [7:0] b);
      logic [8:0] f;
      f = {d, b};
      cs_n <= !sel;
      dc_sel <= d;
      drv[0] <= 1'b0;
      st(4);
      for (int i = three ? 8 : 7; i >= 0; i--) begin
         drv[1] <= f[i];
         st(4);
         drv[0] <= 1'b1;
         st(4);
         drv[0] <= 1'b0;
      end
      st(4);
      cs_n <= 1'b1;
      st(4);
   endtask
   // scl and sda idle high; the ninth slot of each byte is left high for the acknowledge
   task automatic i2c(input logic sa0, input logic [7:0] a, input logic [7:0] c,
      input logic [7:0] b, output int ack);
      logic [26:0] f;
      f = {a, 1'b1, c, 1'b1, b, 1'b1};
      ack = 0;
      cs_n <= 1'b0;
      dc_sel <= sa0;
      drv[1:0] <= 2'h3;
      st(4);
      drv[1] <= 1'b0;
      st(4);
      for (int i = 26; i >= 0; i--) begin
         drv[0] <= 1'b0;
         st(2);
         drv[1] <= f[i];
         st(6);
         drv[0] <= 1'b1;
         st(2);
         if (i % 9 == 0 && !bus_in[1]) ack++;
         st(2);
      end
      drv[0] <= 1'b0;
      st(2);
      drv[1] <= 1'b0;
      st(6);
      drv[0] <= 1'b1;
      st(4);
      drv[1] <= 1'b1;
      st(4);
      cs_n <= 1'b1;
      st(4);
   endtask
   task automatic pwr(input logic p68, input logic d, input logic [7:0] b);
      rw_wr_n <= !p68;
      en_rd_n <= !p68;
      dc_sel <= d;
      drv <= b;
      st(4);
      cs_n <= 1'b0;
      st(4);
      if (p68) en_rd_n <= 1'b1;
      else rw_wr_n <= 1'b0;
      st(4);
      if (p68) en_rd_n <= 1'b0;
      else rw_wr_n <= 1'b1;
      st(4);
      cs_n <= 1'b1;
      st(4);
   endtask
   task automatic prd(input logic p68, output logic [7:0] v);
      rw_wr_n <= 1'b1;
      en_rd_n <= !p68;
      st(4);
      cs_n <= 1'b0;
      drv_en <= 1'b0;
      st(4);
      en_rd_n <= p68;
      st(10);
      v = bus_in;
      en_rd_n <= !p68;
      st(4);
      cs_n <= 1'b1;
      drv_en <= 1'b1;
      st(4);
   endtask
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/10ps
module tb;
   import mmhi_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hw_reset_n = 1'b1;
   logic [2:0] strap = 3'h0;
   logic word_ready = 1'b0;
   logic hold = 1'b0;
   logic cs_n, dc_sel, rw_wr_n, en_rd_n, drv_en;
   logic [7:0] drv, bus_in, bus_out, oe_n, contrast;
   logic word_valid, display_on, overrun, rst_sync;
   logic [6:0] column_addr;
   mmhi_word_type word;
   mmhi_proto_type proto_mode;
   logic [31:0] seed = 32'h8dece0a9;
   // arbitrary upper slave address bits
   localparam logic [5:0] I2C_HI = 6'h1e;
   logic sda_ack;
   mmhi_word_type exp_q[$];
   int bad_count = 0;
   int samples_checked = 0;
   logic [2:0] straps [6] = '{STRAP_I2C, STRAP_SPI3, STRAP_SPI4, STRAP_P68, STRAP_P80, 3'h7};
   mmhi_proto_type modes [6] = '{PROTO_I2C, PROTO_SPI3, PROTO_SPI4, PROTO_P68, PROTO_P80,
      PROTO_NONE};

   always #20 clk = ~clk;
   // released pins show the inverse of the last host value; pins 2 and 1 joined for i2c
   assign sda_ack = !oe_n[2] && !bus_out[2];
   assign bus_in = (oe_n & (drv_en ? drv & ~{6'h00, sda_ack, 1'b0} : ~drv))
      | (~oe_n & bus_out);

   mmhi_host u_host (.clk, .cs_n, .dc_sel, .rw_wr_n, .en_rd_n, .drv, .drv_en, .bus_in);
   mmhi_top #(.I2C_ADDR_HI(I2C_HI)) u_dut (.clk, .rst, .cs_n, .dc_sel, .rw_wr_n, .en_rd_n,
      .hw_reset_n,
      .proto_strap_bit0(strap[0]), .proto_strap_bit1(strap[1]), .proto_strap_bit2(strap[2]),
      .host_bus_in(bus_in), .host_bus_out(bus_out), .host_bus_oe_n(oe_n), .word_valid,
      .word_ready, .word, .proto_mode, .contrast, .column_addr, .display_on, .overrun,
      .hw_reset_n_sync(rst_sync));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic st(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk_word(input mmhi_word_type e, input mmhi_word_type g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH word exp %h got %h", e, g);
      end
   endtask
   task automatic chk_stat(input string n, input logic [8:0] e, input logic [8:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // drain side stalls at random
   always @(posedge clk) word_ready <= !hold && rnd() > 32'h7fffffff;
   always @(posedge clk) begin
      if (!rst && word_valid === 1'b1 && word_ready === 1'b1)
         chk_word(exp_q.size() != 0 ? exp_q.pop_front() : 'x, word);
   end

   task automatic put(input mmhi_proto_type m, input logic d, input logic [7:0] b);
      exp_q.push_back('{d, b});
      if (m == PROTO_SPI3 || m == PROTO_SPI4) u_host.spi(m == PROTO_SPI3, 1'b1, d, b);
      else u_host.pwr(m == PROTO_P68, d, b);
   endtask
   task automatic drain();
      for (int i = 0; i < 3000 && exp_q.size() != 0; i++) st(1);
      chk_stat("queue", 9'h0, 9'(exp_q.size()));
      st(10);
   endtask
   task automatic reset_to(input logic [2:0] s);
      strap <= s;
      rst <= 1'b1;
      st(20);
      rst <= 1'b0;
      st(12);
   endtask
   task automatic run(input mmhi_proto_type m);
      logic [7:0] c;
      logic [7:0] v;
      logic par;
      par = m == PROTO_P68 || m == PROTO_P80;
      c = 8'(rnd());
      put(m, 1'b0, CMD_CONTRAST);
      put(m, 1'b0, c);
      put(m, 1'b0, CMD_DISP_ON);
      put(m, 1'b1, 8'(rnd()));
      put(m, 1'b1, 8'(rnd()));
      if (!par) u_host.spi(m == PROTO_SPI3, 1'b0, 1'b1, 8'h5a);
      drain();
      chk_stat("contrast", c, contrast);
      chk_stat("column", 9'h2, column_addr);
      chk_stat("display", 9'h1, display_on);
      if (par) u_host.prd(m == PROTO_P68, v);
      if (par) chk_stat("status", 9'h00, v);
      hw_reset_n <= 1'b0;
      st(10);
      chk_stat("sync", 9'h0, rst_sync);
      chk_stat("contrast", CONTRAST_RST, contrast);
      chk_stat("column", COLUMN_RST, column_addr);
      chk_stat("display", DISP_ON_RST, display_on);
      hw_reset_n <= 1'b1;
      st(10);
      if (par) u_host.prd(m == PROTO_P68, v);
      if (par) chk_stat("status", 9'h40, v);
   endtask

   task automatic i2c_test();
      int a;
      logic [7:0] b;
      b = 8'(rnd());
      exp_q.push_back('{1'b1, b});
      u_host.i2c(1'b1, {I2C_HI, 2'h2}, 8'h40, b, a);
      chk_stat("ack", 9'h3, 9'(a));
      u_host.i2c(1'b0, {I2C_HI, 2'h2}, 8'h00, b, a);
      chk_stat("ack", 9'h0, 9'(a));
      drain();
   endtask

   initial begin
      st(30000);
      bad_count++;
      end_of_test();
   end
   initial begin
      logic [7:0] b;
      for (int k = 0; k < 6; k++) begin
         reset_to(straps[k]);
         chk_stat("mode", modes[k], proto_mode);
         chk_stat("contrast", CONTRAST_RST, contrast);
         chk_stat("bus_oe", 9'h0ff, oe_n);
         if (modes[k] inside {PROTO_SPI3, PROTO_SPI4, PROTO_P68, PROTO_P80}) run(modes[k]);
         if (modes[k] == PROTO_I2C) i2c_test();
         $display("test mode %0d done", k);
      end
      reset_to(STRAP_SPI4);
      hold <= 1'b1;
      for (int i = 0; i < 18; i++) begin
         b = 8'(rnd());
         if (i < 17) put(PROTO_SPI4, 1'b1, b);
         else u_host.spi(1'b0, 1'b1, 1'b1, b);
      end
      chk_stat("overrun", 9'h1, overrun);
      hold <= 1'b0;
      drain();
      $display("test fill done");
      end_of_test();
   end
endmodule
